// File: src/lfs_avalon_slave.sv
// Avalon-MM slave handshake with one wait state for the line fault status registers.
`timescale 1ns/1ns
`default_nettype none
`include "lfs_consts.svh"
module lfs_avalon_slave
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Avalon-MM
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    output logic waitrequest,
    // Accepted access strobes
    output logic rd_go,
    output logic wr_go
);
    logic wait_reg;

    // Waitrequest idles high and drops for one cycle per request, so it comes from a flip-flop
    // and still gives the top one cycle to register read data.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wait_reg <= 1'b1;
        else
            wait_reg <= !((read || write) && wait_reg);
    end

    assign waitrequest = wait_reg;
    assign rd_go = read && !wait_reg;
    assign wr_go = write && !wait_reg;

    a_single_wait: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(read) |-> waitrequest ##1 !waitrequest)
        else $error("read not answered in two cycles");
endmodule
`default_nettype wire

// File: src/lfs_consts.svh
// Offsets, field positions, reset values and timing counts of the line fault status block.
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH
`define LFS_ADDR_STATUS 8'h08
`define LFS_ADDR_IRQ_STAT 8'h10
`define LFS_ADDR_IRQ_MASK 8'h14
`define LFS_ADDR_CTRL 8'h18
`define LFS_NEG_HI 3
`define LFS_NEG_LO 2
`define LFS_POS_HI 1
`define LFS_POS_LO 0
`define LFS_FAULT_SHORT_SUPPLY 2'h0
`define LFS_FAULT_SHORT_GROUND 2'h1
`define LFS_FAULT_NORMAL 2'h2
`define LFS_FAULT_OPEN 2'h3
`define LFS_STATUS_RESET 8'h0a
`define LFS_IRQ_FAULT_SET 0
`define LFS_IRQ_FAULT_CLEAR 1
`define LFS_IRQ_TYPE_CHANGE 2
`define LFS_IRQ_MASK_RESET 3'h0
`define LFS_CTRL_SLEEP 0
`define LFS_UART_DELAY_US 2700
`define LFS_CLK_MHZ 20
`define LFS_UART_DELAY_CYC (`LFS_UART_DELAY_US * `LFS_CLK_MHZ)
`endif

// File: src/lfs_line_fault_status.sv
// Top of the line fault status block: fault pin, status register, interrupts, pulldowns.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "lfs_consts.svh"
module lfs_line_fault_status
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Detector comparators per cable wire
    input wire lfs_pkg::lfs_wire_det_t neg_det,
    input wire lfs_pkg::lfs_wire_det_t pos_det,
    // Power control
    input wire logic power_down_n,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Device outputs
    output logic cable_fault_n,
    output logic pulldown_en,
    output logic irq,
    output logic uart_ready
);
    lfs_pkg::lfs_fault_pair_t faults;
    lfs_pkg::lfs_fault_t neg_type;
    lfs_pkg::lfs_fault_t pos_type;
    logic rd_go;
    logic wr_go;
    logic wait_int;
    logic any_fault;
    logic fault_d_reg;
    logic [7:0] type_d_reg;
    logic [7:0] status_now;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;
    logic [2:0] irq_event;
    logic sleep_reg;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;
    logic [22:0] delay_cnt_reg;

    if (`LFS_UART_DELAY_CYC >= (1 << 23))
    begin : g_delay_check
        $error("uart delay count does not fit its counter");
    end

    lfs_wire_class u_neg
    (
        .clk(clk),
        .arst_n(arst_n),
        .det(neg_det),
        .fault_type(neg_type)
    );

    lfs_wire_class u_pos
    (
        .clk(clk),
        .arst_n(arst_n),
        .det(pos_det),
        .fault_type(pos_type)
    );

    assign faults = '{neg_wire_fault_type: neg_type, pos_wire_fault_type: pos_type};

    lfs_avalon_slave u_bus
    (
        .clk(clk),
        .arst_n(arst_n),
        .address(address),
        .read(read),
        .write(write),
        .waitrequest(wait_int),
        .rd_go(rd_go),
        .wr_go(wr_go)
    );

    // Waitrequest is registered in the bus slave, so the pin comes straight from its flip-flop.
    assign waitrequest = wait_int;

    assign any_fault = (faults.neg_wire_fault_type != lfs_pkg::LFS_NORMAL)
        || (faults.pos_wire_fault_type != lfs_pkg::LFS_NORMAL);
    assign status_now = {4'h0, 2'(faults.neg_wire_fault_type), 2'(faults.pos_wire_fault_type)};

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cable_fault_n <= 1'b1;
        else
            cable_fault_n <= !any_fault;
    end

    // The pin is unfiltered on purpose; short ground shifts must be filtered by the host.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_d_reg <= 1'b0;
            type_d_reg <= `LFS_STATUS_RESET;
        end
        else
        begin
            fault_d_reg <= any_fault;
            type_d_reg <= status_now;
        end
    end

    assign irq_event[`LFS_IRQ_FAULT_SET] = any_fault && !fault_d_reg;
    assign irq_event[`LFS_IRQ_FAULT_CLEAR] = !any_fault && fault_d_reg;
    assign irq_event[`LFS_IRQ_TYPE_CHANGE] = status_now != type_d_reg;

    // A new event in the read cycle survives the clear-on-read.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_stat_reg <= 3'h0;
        else if (rd_go && address == `LFS_ADDR_IRQ_STAT)
            irq_stat_reg <= irq_event;
        else
            irq_stat_reg <= irq_stat_reg | irq_event;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_mask_reg <= `LFS_IRQ_MASK_RESET;
        else if (wr_go && address == `LFS_ADDR_IRQ_MASK)
            irq_mask_reg <= writedata[2:0];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_reg & irq_mask_reg);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sleep_reg <= 1'b0;
        else if (wr_go && address == `LFS_ADDR_CTRL)
            sleep_reg <= writedata[`LFS_CTRL_SLEEP];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pulldown_en <= 1'b0;
        else
            pulldown_en <= power_down_n && !sleep_reg;
    end

    // The device cannot enforce the host's wait; it only flags when the wait has run out.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            delay_cnt_reg <= 23'h0;
        else if (!power_down_n)
            delay_cnt_reg <= 23'h0;
        else if (delay_cnt_reg != 23'(`LFS_UART_DELAY_CYC))
            delay_cnt_reg <= delay_cnt_reg + 23'h1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            uart_ready <= 1'b0;
        else
            uart_ready <= power_down_n && delay_cnt_reg == 23'(`LFS_UART_DELAY_CYC);
    end

    always_comb
    begin
        readdata_next = 32'h0;
        case (address)
            `LFS_ADDR_STATUS: readdata_next = {24'h0, status_now};
            `LFS_ADDR_IRQ_STAT: readdata_next = {29'h0, irq_stat_reg | irq_event};
            `LFS_ADDR_IRQ_MASK: readdata_next = {29'h0, irq_mask_reg};
            `LFS_ADDR_CTRL: readdata_next = {31'h0, sleep_reg};
            default: readdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            readdata_reg <= 32'h0;
        else if (read && wait_int)
            readdata_reg <= readdata_next;
    end

    assign readdata = readdata_reg;

    a_pin_tracks: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 cable_fault_n == !$past(any_fault))
        else $error("fault pin does not track wire state");

    a_status_read: assert property (@(posedge clk) disable iff (!arst_n)
        (read && !waitrequest && address == `LFS_ADDR_STATUS)
        |-> readdata[3:0] == $past(status_now))
        else $error("status read returns stale data");

    a_neg_field: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 status_now[3:2] == (($past(neg_det.short_supply)) ? 2'h0 :
            $past(neg_det.short_ground) ? 2'h1 :
            $past(neg_det.open) ? 2'h3 : 2'h2))
        else $error("negative wire field wrong");

    a_pos_field: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 status_now[1:0] == (($past(pos_det.short_supply)) ? 2'h0 :
            $past(pos_det.short_ground) ? 2'h1 :
            $past(pos_det.open) ? 2'h3 : 2'h2))
        else $error("positive wire field wrong");

    a_pulldown_off: assert property (@(posedge clk) disable iff (!arst_n)
        (!power_down_n || sleep_reg) |=> !pulldown_en)
        else $error("pulldowns left on in power down");

    a_uart_early: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(uart_ready) |-> delay_cnt_reg == 23'(`LFS_UART_DELAY_CYC))
        else $error("uart ready raised early");

    a_irq_level: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 irq == |($past(irq_stat_reg) & $past(irq_mask_reg)))
        else $error("interrupt level wrong");

    a_fault_event: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(any_fault) |=> irq_stat_reg[`LFS_IRQ_FAULT_SET])
        else $error("fault event not latched");
endmodule
`default_nettype wire

// File: src/lfs_pkg.sv
// Types shared by the line fault status block.
package lfs_pkg;
    typedef enum logic [1:0] {
        LFS_SHORT_SUPPLY,
        LFS_SHORT_GROUND,
        LFS_NORMAL,
        LFS_OPEN
    } lfs_fault_t;

    typedef struct packed {
        logic short_supply;
        logic short_ground;
        logic open;
    } lfs_wire_det_t;

    typedef struct packed {
        lfs_fault_t neg_wire_fault_type;
        lfs_fault_t pos_wire_fault_type;
    } lfs_fault_pair_t;
endpackage

// File: src/lfs_wire_class.sv
// Classifies one cable wire's detector comparators into a registered fault type.
`timescale 1ns/1ns
`default_nettype none
`include "lfs_consts.svh"
module lfs_wire_class
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Detector comparators
    input wire lfs_pkg::lfs_wire_det_t det,
    // Classified fault type
    output var lfs_pkg::lfs_fault_t fault_type
);
    // Supply short is ranked first because it is the case most likely to damage the driver.
    function automatic lfs_pkg::lfs_fault_t classify(input lfs_pkg::lfs_wire_det_t d);
        if (d.short_supply)
            classify = lfs_pkg::LFS_SHORT_SUPPLY;
        else if (d.short_ground)
            classify = lfs_pkg::LFS_SHORT_GROUND;
        else if (d.open)
            classify = lfs_pkg::LFS_OPEN;
        else
            classify = lfs_pkg::LFS_NORMAL;
    endfunction

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            fault_type <= lfs_pkg::LFS_NORMAL;
        else
            fault_type <= classify(det);
    end

    a_class_follows: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 fault_type == classify($past(det)))
        else $error("wire class does not follow detector");
endmodule
`default_nettype wire

// File: tb/lfs_cable_model.sv
// Cable model that turns a requested fault per wire into detector comparator levels.
`timescale 1ns/1ns
`default_nettype none
module lfs_cable_model
(
    // Requested fault type per wire
    input wire lfs_pkg::lfs_fault_pair_t codes,
    // High makes lower-ranked comparators fire along with the real one
    input wire logic stack,
    // Comparator levels seen by the block
    output var lfs_pkg::lfs_wire_det_t neg_det,
    output var lfs_pkg::lfs_wire_det_t pos_det
);
    // Stacked comparators stress the priority order; the expected type stays the requested one.
    function automatic lfs_pkg::lfs_wire_det_t to_det(input lfs_pkg::lfs_fault_t f,
        input logic s);
        return '{short_supply: f == lfs_pkg::LFS_SHORT_SUPPLY,
                 short_ground: f == lfs_pkg::LFS_SHORT_GROUND
                     || (s && f == lfs_pkg::LFS_SHORT_SUPPLY),
                 open: f == lfs_pkg::LFS_OPEN
                     || (s && (f == lfs_pkg::LFS_SHORT_SUPPLY || f == lfs_pkg::LFS_SHORT_GROUND))};
    endfunction
    always_comb neg_det = to_det(codes.neg_wire_fault_type, stack);
    always_comb pos_det = to_det(codes.pos_wire_fault_type, stack);
endmodule
`default_nettype wire

// File: tb/line_fault_status_bench.sv
// Self-checking bench for the line fault status block.
`timescale 1ns/1ns
`default_nettype none
`include "lfs_consts.svh"
module line_fault_status_bench;
    logic clk;
    logic arst_n;
    logic power_down_n;
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic cable_fault_n;
    logic pulldown_en;
    logic irq;
    logic uart_ready;
    lfs_pkg::lfs_fault_pair_t codes;
    logic stack;
    lfs_pkg::lfs_wire_det_t neg_det;
    lfs_pkg::lfs_wire_det_t pos_det;
    int miscompares;
    int checks_done;
    logic [31:0] q;
    logic [1:0] n;
    logic [1:0] p;

    lfs_cable_model cable (.codes(codes), .stack(stack), .neg_det(neg_det), .pos_det(pos_det));
    lfs_line_fault_status DUT (.clk(clk), .arst_n(arst_n), .neg_det(neg_det),
        .pos_det(pos_det), .power_down_n(power_down_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .cable_fault_n(cable_fault_n),
        .pulldown_en(pulldown_en), .irq(irq), .uart_ready(uart_ready));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic exp_fault_n(input logic [1:0] a, input logic [1:0] b);
        return a == `LFS_FAULT_NORMAL && b == `LFS_FAULT_NORMAL;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Called just after a rising edge; returns just after one.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= d;
        // Waitrequest and read data are registered, so just after an edge they still show
        // what that edge sampled; only the watchdog ends a wait that never comes.
        do
            @(posedge clk);
        while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    // Sets both wires, lets the result settle and stops at a falling edge for sampling.
    task automatic wires(input logic [1:0] a, input logic [1:0] b);
        codes <= '{lfs_pkg::lfs_fault_t'(a), lfs_pkg::lfs_fault_t'(b)};
        stack <= 1'($urandom);
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        close_out;
    end

    initial
    begin
        arst_n = 1'b0;
        power_down_n = 1'b1;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        codes = '{lfs_pkg::LFS_NORMAL, lfs_pkg::LFS_NORMAL};
        stack = 1'b0;
        miscompares = 0;
        checks_done = 0;
        void'($urandom(32'h461f));
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, `LFS_ADDR_STATUS, 32'h0);
        chk(q, {24'h0, `LFS_STATUS_RESET});
        chk({31'h0, pulldown_en}, 32'h1);
        bus(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        // Every code pair once, then random pairs to catch history effects.
        for (int i = 0; i < 28; i++)
        begin
            {n, p} = (i < 16) ? 4'(i) : 4'($urandom);
            wires(n, p);
            chk({31'h0, cable_fault_n}, {31'h0, exp_fault_n(n, p)});
            @(posedge clk);
            bus(1'b1, `LFS_ADDR_STATUS, 32'hff);
            bus(1'b0, `LFS_ADDR_STATUS, 32'h0);
            chk(q, {28'h0, n, p});
        end
        wires(`LFS_FAULT_NORMAL, `LFS_FAULT_NORMAL);
        @(posedge clk);
        bus(1'b0, `LFS_ADDR_IRQ_STAT, 32'h0);
        bus(1'b1, `LFS_ADDR_IRQ_MASK, 32'h7);
        bus(1'b0, `LFS_ADDR_IRQ_MASK, 32'h0);
        chk(q, 32'h7);
        wires(`LFS_FAULT_OPEN, `LFS_FAULT_NORMAL);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        bus(1'b0, `LFS_ADDR_IRQ_STAT, 32'h0);
        chk(q, (32'h1 << `LFS_IRQ_FAULT_SET) | (32'h1 << `LFS_IRQ_TYPE_CHANGE));
        bus(1'b1, `LFS_ADDR_IRQ_MASK, 32'h0);
        wires(`LFS_FAULT_NORMAL, `LFS_FAULT_NORMAL);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk);
        bus(1'b0, `LFS_ADDR_IRQ_STAT, 32'h0);
        chk(q, (32'h1 << `LFS_IRQ_FAULT_CLEAR) | (32'h1 << `LFS_IRQ_TYPE_CHANGE));
        for (int s = 1; s >= 0; s--)
        begin
            bus(1'b1, `LFS_ADDR_CTRL, 32'(s));
            repeat (2) @(posedge clk);
            chk({31'h0, pulldown_en}, 32'(1 - s));
        end
        power_down_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk({30'h0, pulldown_en, uart_ready}, 32'h0);
        power_down_n <= 1'b1;
        repeat (53900) @(posedge clk);
        chk({31'h0, uart_ready}, 32'h0);
        for (int k = 0; k < 300 && uart_ready !== 1'b1; k++)
            @(posedge clk);
        chk({31'h0, uart_ready}, 32'h1);
        close_out;
    end
endmodule
`default_nettype wire
